//--- gate_ctrl_asserts.sv
`timescale 1ns/1ps
`include "gate_ctrl_defs.vh"
// ----
// port checker
// ----
module gate_ctrl_asserts #(
  parameter T_RST_WINDOW_NS = `T_RST_WINDOW_NS
) (
  input logic i_clk,
  input logic i_nrst,
  input logic i_enable,
  input logic i_motor_supply_ok,
  input logic i_fault_cond,
  input logic i_scs_n,
  input logic o_sdo,
  input logic o_sdo_oe,
  input logic o_high_side_gate_en,
  input logic o_low_side_gate_en,
  input logic o_gate_pulldown,
  input logic o_charge_pump_rail_en,
  input logic o_sense_amp_en,
  input logic o_serial_en,
  input logic o_digital_supply_regulator_en,
  input logic [`DATA_BITS-1:0] o_driver_ctrl
);
  localparam int LONG_LOW = T_RST_WINDOW_NS / `CLK_PERIOD_NS + 12;
  int low_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // enable low run length, saturates so it never wraps
  always @(posedge i_clk) begin
    if (!i_nrst || i_enable) begin
      low_cnt <= 0;
    end else if (low_cnt < LONG_LOW) begin
      low_cnt <= low_cnt + 1;
    end
  end
  // margins cover the four-flop pin latency plus output register
  sdo_released_a: assert property (i_scs_n [*8] |-> !o_sdo_oe)
    else $error("serial output pulled while deselected");
  open_drain_a: assert property (o_sdo_oe |-> !o_sdo)
    else $error("serial output drives high");
  gates_pulled_a: assert property (!o_high_side_gate_en && !o_low_side_gate_en |-> o_gate_pulldown)
    else $error("gates off but not pulled down");
  sleep_outputs_a: assert property (!o_digital_supply_regulator_en |-> !o_serial_en
    && !o_sense_amp_en && !o_charge_pump_rail_en && !o_high_side_gate_en)
    else $error("block active while asleep");
  long_low_a: assert property (low_cnt == LONG_LOW |-> !o_serial_en && o_driver_ctrl == '0)
    else $error("long enable low did not sleep");
  wake_up_a: assert property ($rose(i_enable) ##1 (i_enable && i_motor_supply_ok) [*8]
    |-> o_serial_en && o_digital_supply_regulator_en)
    else $error("no wake with enable and supply");
  supply_lockout_a: assert property (!i_motor_supply_ok [*8]
    |-> !o_high_side_gate_en && !o_low_side_gate_en)
    else $error("gates on under lockout");
  fault_gate_a: assert property (i_fault_cond [*8] |-> !o_high_side_gate_en && !o_low_side_gate_en)
    else $error("gates on during fault");
  write_commit_a: assert property (!$stable(o_driver_ctrl) |-> (i_scs_n && $past(i_scs_n, 2))
    || o_driver_ctrl == '0)
    else $error("register changed inside a frame");
  cover property ($fell(i_scs_n));
  cover property ($fell(o_serial_en));
  cover property ($rose(o_high_side_gate_en));
endmodule // gate_ctrl_asserts

bind gate_driver_spi_and_mode_ctrl gate_ctrl_asserts #(
  .T_RST_WINDOW_NS(T_RST_WINDOW_NS)
) chk (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_enable(i_enable),
  .i_motor_supply_ok(i_motor_supply_ok),
  .i_fault_cond(i_fault_cond),
  .i_scs_n(i_scs_n),
  .o_sdo(o_sdo),
  .o_sdo_oe(o_sdo_oe),
  .o_high_side_gate_en(o_high_side_gate_en),
  .o_low_side_gate_en(o_low_side_gate_en),
  .o_gate_pulldown(o_gate_pulldown),
  .o_charge_pump_rail_en(o_charge_pump_rail_en),
  .o_sense_amp_en(o_sense_amp_en),
  .o_serial_en(o_serial_en),
  .o_digital_supply_regulator_en(o_digital_supply_regulator_en),
  .o_driver_ctrl(o_driver_ctrl)
);

//--- gate_ctrl_defs.vh
`ifndef GATE_CTRL_DEFS_VH
`define GATE_CTRL_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define T_RST_WINDOW_NS 20000
`define T_CS_HIGH_MIN_NS 400

// ----------------------------------------
// serial word layout
// ----------------------------------------
`define WORD_BITS 16
`define CMD_BITS 5
`define DATA_BITS 11
`define RW_POS 15
`define ADDR_MSB 14
`define ADDR_LSB 11
`define RW_WRITE 1'h0
`define RW_READ 1'h1

// ----------------------------------------
// register addresses
// ----------------------------------------
`define REG_FAULT_STATUS 4'h0
`define REG_WARN_STATUS 4'h1
`define REG_DRIVER_CTRL 4'h2
`define REG_LAST 4'h7

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CLEAR_FAULT_POS 0
`define ST_FAULT_POS 10
`define ST_LATCHED_POS 8
`define ST_UVLO_POS 7
`define ST_THERMAL_POS 6
`define WARN_OVERTEMP_POS 7
`define CFG_RESET 11'h000

`endif

//--- gate_driver_spi_and_mode_ctrl.v
`timescale 1ns/1ps
`include "gate_ctrl_defs.vh"

module gate_driver_spi_and_mode_ctrl #(
  parameter T_RST_WINDOW_NS = `T_RST_WINDOW_NS,
  parameter CNT_W = 16
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_enable,
  input wire i_motor_supply_ok,
  input wire i_fault_cond,
  input wire i_overtemp,
  input wire i_sclk,
  input wire i_scs_n,
  input wire i_sdi,
  output reg o_sdo,
  output reg o_sdo_oe,
  output reg o_high_side_gate_en,
  output reg o_low_side_gate_en,
  output reg o_gate_pulldown,
  output reg o_charge_pump_rail_en,
  output reg o_low_side_gate_regulator_en,
  output reg o_digital_supply_regulator_en,
  output reg o_sense_amp_en,
  output reg o_serial_en,
  output reg o_fault_n,
  output reg [`DATA_BITS-1:0] o_driver_ctrl
);
  // longest low time of a reset pulse, rounded down, at least one cycle
  localparam RST_CYC_RAW = T_RST_WINDOW_NS / `CLK_PERIOD_NS;
  localparam RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
  localparam [CNT_W-1:0] RST_LIMIT = RST_CYC[CNT_W-1:0];

  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_FAULT = 3'h4;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  wire [7:0] lvl;
  wire [7:0] rise;
  wire [7:0] fall;

  // order: sdi, scs_n, sclk, overtemp, fault, supply, enable, spare
  // reset levels match idle pins: select high, enable low, so no false edge follows
  pin_sync #(
    .WIDTH(8),
    .RESET_VAL(8'h02)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin({1'b0, i_enable, i_motor_supply_ok, i_fault_cond, i_overtemp,
            i_sclk, i_scs_n, i_sdi}),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );

  wire sdi = lvl[0];
  wire scs_n = lvl[1];
  wire scs_fall = fall[1];
  wire scs_rise = rise[1];
  wire sclk_rise = rise[2];
  wire sclk_fall = fall[2];
  wire overtemp = lvl[3];
  wire fault_cond = lvl[4];
  wire supply_ok = lvl[5];
  wire en = lvl[6];
  wire en_rise = rise[6];

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] low_cnt;
  reg thermal_flag;
  reg clear_req;
  reg [`WORD_BITS-1:0] rx_shift;
  reg [`DATA_BITS-1:0] tx_shift;
  reg [4:0] bit_cnt;
  reg in_frame;
  reg sdo_bit;
  reg [`DATA_BITS-1:0] cfg [2:7];
  integer k;

  wire sleeping = state[0];
  wire long_low = !en && (low_cnt > RST_LIMIT);
  // high-low-high with the low phase inside the window
  wire valid_pulse = en_rise && (low_cnt != {CNT_W{1'b0}}) &&
                     (low_cnt <= RST_LIMIT) && !sleeping;
  wire fault_reset = clear_req || valid_pulse;
  wire frame_ok = (bit_cnt == 5'h10);
  wire is_write = (rx_shift[`RW_POS] == `RW_WRITE);
  wire [3:0] rx_addr = rx_shift[`ADDR_MSB:`ADDR_LSB];
  wire [`DATA_BITS-1:0] rx_data = rx_shift[`DATA_BITS-1:0];

  // storage window of the map; status and unmapped addresses stay read-only
  function in_storage;
    input [3:0] a;
    begin
      in_storage = (a >= `REG_DRIVER_CTRL) && (a <= `REG_LAST);
    end
  endfunction

  // gate drive needs operating mode, a good supply and a cool die
  function drive_ok;
    input [2:0] st;
    input sup;
    input hot;
    begin
      drive_ok = st[1] && sup && !hot;
    end
  endfunction

  // read side of the register file; addresses past the map read as zero
  function [`DATA_BITS-1:0] read_word;
    input [3:0] a;
    begin
      read_word = `CFG_RESET;
      case (a)
        `REG_FAULT_STATUS: begin
          read_word[`ST_FAULT_POS] = state[2] | thermal_flag | ~supply_ok | overtemp;
          read_word[`ST_LATCHED_POS] = state[2];
          read_word[`ST_UVLO_POS] = ~supply_ok;
          read_word[`ST_THERMAL_POS] = thermal_flag;
        end
        `REG_WARN_STATUS: begin
          read_word[`WARN_OVERTEMP_POS] = overtemp;
        end
        default: begin
          if (in_storage(a)) begin
            read_word = cfg[a[2:0]];
          end
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // mode sequencing
  // ----------------------------------------
  // next mode from enable, supply and the latched fault
  always @* begin
    next_state = state;
    case (state)
      ST_SLEEP: begin
        if (en && supply_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (long_low) begin
          next_state = ST_SLEEP;
        end else if (fault_cond) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (long_low) begin
          next_state = ST_SLEEP;
        end else if (!fault_cond && fault_reset) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_SLEEP;
      end
    endcase
  end

  // low-phase timer; saturates one past the window
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= ST_SLEEP;
      low_cnt <= {CNT_W{1'b0}};
    end else begin
      state <= next_state;
      if (en) begin
        low_cnt <= {CNT_W{1'b0}};
      end else if (low_cnt <= RST_LIMIT) begin
        low_cnt <= low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // thermal flag outlives the condition; a new event beats a clear
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      thermal_flag <= 1'b0;
    end else if (sleeping) begin
      thermal_flag <= 1'b0;
    end else if (overtemp) begin
      thermal_flag <= 1'b1;
    end else if (fault_reset) begin
      thermal_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // serial receive and frame check
  // ----------------------------------------
  // bit counter saturates at 17 so overruns still read as frame errors
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      in_frame <= 1'b0;
      bit_cnt <= 5'h00;
      rx_shift <= 16'h0000;
      tx_shift <= `CFG_RESET;
      sdo_bit <= 1'b1;
    end else if (sleeping || scs_n) begin
      in_frame <= 1'b0;
      bit_cnt <= 5'h00;
      sdo_bit <= 1'b1;
      if (scs_fall && !sleeping) begin
        in_frame <= 1'b1;
      end
    end else begin
      if (scs_fall) begin
        in_frame <= 1'b1;
      end
      if (in_frame && sclk_fall) begin
        rx_shift <= {rx_shift[`WORD_BITS-2:0], sdi};
        if (bit_cnt != 5'h11) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
        // address complete on the fifth falling edge: latch the old contents
        if (bit_cnt == 5'h04) begin
          tx_shift <= read_word({rx_shift[2:0], sdi});
        end
      end
      if (in_frame && sclk_rise) begin
        if (bit_cnt >= 5'h05 && bit_cnt <= 5'h0f) begin
          sdo_bit <= tx_shift[`DATA_BITS-1];
          tx_shift <= {tx_shift[`DATA_BITS-2:0], 1'b1};
        end else begin
          sdo_bit <= 1'b1; // don't-care command slots left released
        end
      end
    end
  end

  // ----------------------------------------
  // register writes at frame end
  // ----------------------------------------
  // commit only on the select rise after exactly sixteen clocks
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      clear_req <= 1'b0;
      for (k = 2; k <= 7; k = k + 1) begin
        cfg[k] <= `CFG_RESET;
      end
    end else if (sleeping) begin
      clear_req <= 1'b0;
      for (k = 2; k <= 7; k = k + 1) begin
        cfg[k] <= `CFG_RESET;
      end
    end else begin
      clear_req <= 1'b0;
      if (scs_rise && in_frame && frame_ok && is_write &&
          in_storage(rx_addr)) begin
        cfg[rx_addr[2:0]] <= rx_data;
        if (rx_addr == `REG_DRIVER_CTRL) begin
          // clear-fault bit is a strobe, it never reads back as one
          cfg[rx_addr[2:0]][`CLEAR_FAULT_POS] <= 1'b0;
          clear_req <= rx_data[`CLEAR_FAULT_POS];
        end
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // gate drive switches off in sleep, lockout, latched fault or overtemperature
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
      o_high_side_gate_en <= 1'b0;
      o_low_side_gate_en <= 1'b0;
      o_gate_pulldown <= 1'b1;
      o_charge_pump_rail_en <= 1'b0;
      o_low_side_gate_regulator_en <= 1'b0;
      o_digital_supply_regulator_en <= 1'b0;
      o_sense_amp_en <= 1'b0;
      o_serial_en <= 1'b0;
      o_fault_n <= 1'b1;
      o_driver_ctrl <= `CFG_RESET;
    end else begin
      o_sdo <= 1'b0; // open drain: only ever pulls low
      o_sdo_oe <= !sleeping && !scs_n && in_frame && !sdo_bit;
      o_high_side_gate_en <= drive_ok(state, supply_ok, overtemp);
      o_low_side_gate_en <= drive_ok(state, supply_ok, overtemp);
      o_gate_pulldown <= !drive_ok(state, supply_ok, overtemp);
      o_charge_pump_rail_en <= !sleeping && !overtemp;
      o_low_side_gate_regulator_en <= !sleeping;
      o_digital_supply_regulator_en <= !sleeping;
      o_sense_amp_en <= !sleeping;
      o_serial_en <= !sleeping;
      o_fault_n <= !(state[2] || overtemp || (!sleeping && !supply_ok));
      o_driver_ctrl <= cfg[2];
    end
  end
endmodule // gate_driver_spi_and_mode_ctrl

//--- gate_driver_spi_and_mode_ctrl_test.sv
`timescale 1ns/1ps
module gate_driver_spi_and_mode_ctrl_test;
  logic i_clk, i_nrst, i_enable, i_motor_supply_ok, i_fault_cond, i_overtemp;
  logic i_sclk, i_scs_n, i_sdi, o_sdo, o_sdo_oe, o_high_side_gate_en, o_low_side_gate_en;
  logic o_gate_pulldown, o_charge_pump_rail_en, o_low_side_gate_regulator_en;
  logic o_digital_supply_regulator_en, o_sense_amp_en, o_serial_en, o_fault_n;
  logic [10:0] o_driver_ctrl;
  logic [15:0] rd;
  logic [10:0] exp_reg [16] = '{default: 11'h000};
  int bad [3] = '{15, 17, 1};
  int num_errors = 0;
  int n_compared = 0;
  int seed = 82;
  wire sdo_line = o_sdo_oe ? o_sdo : 1'h1; // pull-up on open drain
  // ----
  // design and master
  // ----
  gate_driver_spi_and_mode_ctrl #(.T_RST_WINDOW_NS(500)) uut (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_enable(i_enable),
    .i_motor_supply_ok(i_motor_supply_ok),
    .i_fault_cond(i_fault_cond),
    .i_overtemp(i_overtemp),
    .i_sclk(i_sclk),
    .i_scs_n(i_scs_n),
    .i_sdi(i_sdi),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .o_high_side_gate_en(o_high_side_gate_en),
    .o_low_side_gate_en(o_low_side_gate_en),
    .o_gate_pulldown(o_gate_pulldown),
    .o_charge_pump_rail_en(o_charge_pump_rail_en),
    .o_low_side_gate_regulator_en(o_low_side_gate_regulator_en),
    .o_digital_supply_regulator_en(o_digital_supply_regulator_en),
    .o_sense_amp_en(o_sense_amp_en),
    .o_serial_en(o_serial_en),
    .o_fault_n(o_fault_n),
    .o_driver_ctrl(o_driver_ctrl)
  );
  spi_master_model m (.i_sdo_line(sdo_line), .o_sclk(i_sclk), .o_scs_n(i_scs_n), .o_sdi(i_sdi));
  // 200 MHz clock
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ----
  // helpers
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic acc(input logic rw, input logic [3:0] a, input logic [10:0] d, input int n = 16);
    m.xfer({rw, a, d}, n, rd); // flag, address, data
  endtask
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // clear-fault position reads back as zero
  function automatic logic [10:0] stored(input logic [3:0] a, input logic [10:0] d);
    return (a == 4'h2) ? {d[10:1], 1'h0} : d;
  endfunction
  task automatic pulse_enable();
    i_enable = 1'h0; // short low, inside the window
    tick(20);
    i_enable = 1'h1;
    tick(20);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [3:0] a;
    logic [10:0] d;
    {i_nrst, i_enable, i_fault_cond, i_overtemp} = 4'h0;
    i_motor_supply_ok = 1'h1;
    tick(10);
    i_nrst = 1'h1;
    tick(2);
    check("asleep", 3'h1, {o_serial_en, o_high_side_gate_en, o_gate_pulldown});
    i_enable = 1'h1; // traffic only after the wake time
    tick(20);
    check("awake", 5'h1d, {o_serial_en, o_high_side_gate_en, o_charge_pump_rail_en,
      o_gate_pulldown, o_fault_n});
    for (int k = 0; k < 24; k++) begin
      a = 4'($random(seed));
      d = 11'($random(seed));
      acc(1'h0, a, d); // write flag zero
      check("old contents", exp_reg[a], rd[10:0]);
      if (a >= 4'h2 && a <= 4'h7) exp_reg[a] = stored(a, d);
      acc(1'h1, a, 11'h000);
      check("read back", exp_reg[a], rd[10:0]);
      check("driver control", exp_reg[2], o_driver_ctrl);
    end
    foreach (bad[j]) begin
      acc(1'h0, 4'h3, ~exp_reg[3], bad[j]);
      acc(1'h1, 4'h3, 11'h000);
      check("after bad frame", exp_reg[3], rd[10:0]);
    end
    i_motor_supply_ok = 1'h0;
    tick(12);
    check("lockout", 3'h1, {o_high_side_gate_en, o_low_side_gate_en, o_gate_pulldown});
    acc(1'h1, 4'h0, 11'h000);
    check("lockout status", 11'h480, rd[10:0]);
    i_motor_supply_ok = 1'h1;
    i_fault_cond = 1'h1;
    tick(12);
    i_fault_cond = 1'h0;
    tick(12);
    check("latched fault", 3'h1, {o_fault_n, o_high_side_gate_en, o_gate_pulldown});
    acc(1'h1, 4'h0, 11'h000);
    check("fault status", 11'h500, rd[10:0]);
    pulse_enable();
    check("pulse restores", 3'h7, {o_fault_n, o_high_side_gate_en, o_serial_en});
    check("settings kept", exp_reg[2], o_driver_ctrl);
    i_fault_cond = 1'h1;
    tick(12);
    i_fault_cond = 1'h0;
    tick(12);
    acc(1'h0, 4'h2, exp_reg[2] | 11'h001);
    tick(12);
    check("clear bit restores", 2'h3, {o_fault_n, o_high_side_gate_en});
    check("clear bit stored", exp_reg[2], o_driver_ctrl);
    i_overtemp = 1'h1;
    tick(12);
    check("overtemp", 3'h0, {o_charge_pump_rail_en, o_high_side_gate_en, o_fault_n});
    acc(1'h1, 4'h1, 11'h000);
    check("warning status", 11'h080, rd[10:0]);
    i_overtemp = 1'h0;
    tick(12);
    acc(1'h1, 4'h0, 11'h000);
    check("thermal held", 1'h1, rd[6]);
    pulse_enable();
    acc(1'h1, 4'h0, 11'h000);
    check("thermal cleared", 11'h000, rd[10:0]);
    i_enable = 1'h0;
    tick(130);
    check("sleep", {8'h01, 11'h000}, {o_serial_en, o_digital_supply_regulator_en,
      o_sense_amp_en, o_low_side_gate_regulator_en, o_charge_pump_rail_en,
      o_high_side_gate_en, o_low_side_gate_en, o_gate_pulldown, o_driver_ctrl});
    acc(1'h1, 4'h3, 11'h000);
    check("frame in sleep", 16'hffff, rd);
    i_enable = 1'h1;
    tick(20);
    acc(1'h1, 4'h3, 11'h000);
    check("defaults", 11'h000, rd[10:0]);
    report_and_stop();
  end
endmodule // gate_driver_spi_and_mode_ctrl_test

//--- pin_sync.v
`timescale 1ns/1ps
// three-stage sampler for asynchronous pins with agreement filter
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_nrst,
  input wire [WIDTH-1:0] i_pin,
  output reg [WIDTH-1:0] o_level,
  output reg [WIDTH-1:0] o_rise,
  output reg [WIDTH-1:0] o_fall
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  reg [WIDTH-1:0] agree;

  // agreement of stages two and three only; first stage feeds stage two alone
  always @* begin
    agree = ~(stage2 ^ stage3);
  end

  // ----------------------------------------
  // sampling chain and edge pulses
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      o_level <= RESET_VAL;
      o_rise <= {WIDTH{1'b0}};
      o_fall <= {WIDTH{1'b0}};
    end else begin
      meta <= i_pin;
      stage2 <= meta;
      stage3 <= stage2;
      o_level <= (agree & stage3) | (~agree & o_level);
      o_rise <= agree & stage3 & ~o_level;
      o_fall <= agree & ~stage3 & o_level;
    end
  end
endmodule // pin_sync

//--- spi_master_model.sv
`timescale 1ns/1ps
// ----
// serial master, clock runs only inside frames
// ----
module spi_master_model (
  input logic i_sdo_line,
  output logic o_sclk,
  output logic o_scs_n,
  output logic o_sdi
);
  // idle: deselected, clock low
  initial begin
    o_sclk = 1'h0;
    o_scs_n = 1'h1;
    o_sdi = 1'h0;
  end
  // n clocks of a word; reply gathered on falling edges
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_scs_n = 1'h0; // clock low at select edge
    o_sdi = w[15]; // msb first
    #80;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'h1;
      if (i > 0) begin
        w = w << 1;
        o_sdi = w[15]; // change on rising edge
      end
      #80;
      o_sclk = 1'h0;
      r = {r[14:0], i_sdo_line}; // sample on falling edge
      #80;
    end
    o_scs_n = 1'h1;
    o_sdi = ~o_sdi; // stale data must not look valid
    #480; // deselect gap above the minimum
  endtask
endmodule // spi_master_model
